// ### design/adcdma_top.sv
// conversion-result dma: stores each result as a byte pair in the rf
// assumes the converter pulses done with stable channel and data,
// and the register file takes one byte write per cycle when ready
// status flags are polled by software; there is no interrupt
`timescale 1ns/1ps
// Summary of operation
// - results go to rf block chosen by base
// - upper seven address bits from base 7:1
// - low five bits are twice input number plus byte select
// - each ten-bit result becomes two bytes
// - high part even address, rest odd address
module adcdma_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic conv_done,
    input wire logic [3:0] conv_channel,
    input wire logic [9:0] conv_result,
    output logic conv_ready,
    output logic rf_wr_en,
    output logic [11:0] rf_wr_addr,
    output logic [7:0] rf_wr_data,
    input wire logic rf_wr_ready
);
    // ************************************************************
    // register slave state
    // ************************************************************
    logic [7:0] base_reg, base_next;
    logic aw_hold_reg, aw_hold_next;
    logic w_hold_reg, w_hold_next;
    logic [31:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [15:0] stored_reg, stored_next;

    // ************************************************************
    // transfer engine state
    // ************************************************************
    adcdma_pkg::adcdma_state_t state_reg, state_next;
    logic [3:0] chan_reg, chan_next;
    logic [9:0] res_reg, res_next;
    logic [6:0] blk_reg, blk_next;
    logic wr_en_reg, wr_en_next;
    logic [11:0] wr_addr_reg, wr_addr_next;
    logic [7:0] wr_data_reg, wr_data_next;
    logic [11:0] addr_hi, addr_lo;
    logic aw_have, w_have, do_write;
    logic [31:0] wa, wd;
    logic [3:0] ws;
    logic pair_done;

    // ************************************************************
    // address formers for the even and odd byte
    // ************************************************************
    // two plain formers instead of a mux keep the address path short
    adcdma_addr_gen u_gen_hi (
        .base_bits(blk_reg),
        .channel(chan_reg),
        .odd_byte(1'b0),
        .rf_addr(addr_hi)
    );

    adcdma_addr_gen u_gen_lo (
        .base_bits(blk_reg),
        .channel(chan_reg),
        .odd_byte(1'b1),
        .rf_addr(addr_lo)
    );
    // handshake outputs
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // engine side: ready only while idle, so busy dones are dropped
    assign conv_ready = (state_reg == adcdma_pkg::ADCDMA_IDLE);
    assign rf_wr_en = wr_en_reg;
    assign rf_wr_addr = wr_addr_reg;
    assign rf_wr_data = wr_data_reg;

    // ************************************************************
    // axi4-lite write and read paths
    // ************************************************************
    // address and data may arrive in either order; held until both
    always_comb begin
        aw_have = aw_hold_reg || s_axi_awvalid;
        w_have = w_hold_reg || s_axi_wvalid;
        wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
        wd = w_hold_reg ? wdata_reg : s_axi_wdata;
        ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;
        do_write = aw_have && w_have && !bvalid_reg;
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        base_next = base_reg;
        // capture whichever half arrives first
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        // both halves present: decode, answer and release them
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            if (wa[13:2] == adcdma_pkg::ADCDMA_BASE_IDX) begin
                bresp_next = adcdma_pkg::ADCDMA_RESP_OKAY;
                if (ws[0]) begin
                    // bit 0 is reserved and never stored
                    base_next = {wd[7:1], 1'b0};
                end
            end else if (wa[13:2] == adcdma_pkg::ADCDMA_STAT_IDX) begin
                bresp_next = adcdma_pkg::ADCDMA_RESP_OKAY;
            end else begin
                bresp_next = adcdma_pkg::ADCDMA_RESP_SLVERR;
            end
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // read decode; unmapped offsets answer slverr with zero data
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        // address taken: answer next cycle from the decode below
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = adcdma_pkg::ADCDMA_RESP_OKAY;
            if (s_axi_araddr[13:2] == adcdma_pkg::ADCDMA_BASE_IDX) begin
                rdata_next = {24'h00_0000, base_reg};
            end else if (s_axi_araddr[13:2] ==
                         adcdma_pkg::ADCDMA_STAT_IDX) begin
                rdata_next = {14'h0000, state_reg, stored_reg};
            end else begin
                rdata_next = 32'h0000_0000;
                rresp_next = adcdma_pkg::ADCDMA_RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // write-side flops; base comes up at a known value, not undefined
    always_ff @(posedge core_clk) begin
        if (reset) begin
            base_reg <= adcdma_pkg::ADCDMA_BASE_RST;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= adcdma_pkg::ADCDMA_RESP_OKAY;
        end else begin
            base_reg <= base_next;
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    // read-side flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= adcdma_pkg::ADCDMA_RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ************************************************************
    // byte-pair transfer engine
    // ************************************************************
    // result and base are captured at done, so a base write mid-pair
    // cannot split one result across two blocks
    always_comb begin
        state_next = state_reg;
        chan_next = chan_reg;
        res_next = res_reg;
        blk_next = blk_reg;
        wr_en_next = wr_en_reg;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        pair_done = 1'b0;
        case (state_reg)
            adcdma_pkg::ADCDMA_IDLE: begin
                wr_en_next = 1'b0;
                // a busy done never reaches here, so it is lost
                if (conv_done) begin
                    chan_next = conv_channel;
                    res_next = conv_result;
                    blk_next = base_reg[adcdma_pkg::ADCDMA_BASE_MSB:
                                        adcdma_pkg::ADCDMA_BASE_LSB];
                    state_next = adcdma_pkg::ADCDMA_WR_HI;
                end
            end
            adcdma_pkg::ADCDMA_WR_HI: begin
                // present even byte: upper eight bits of the result
                if (!wr_en_reg) begin
                    wr_en_next = 1'b1;
                    wr_addr_next = addr_hi;
                    wr_data_next = res_reg[9:2];
                end else if (rf_wr_ready) begin
                    wr_addr_next = addr_lo;
                    wr_data_next = {6'b00_0000, res_reg[1:0]};
                    state_next = adcdma_pkg::ADCDMA_WR_LO;
                end
            end
            adcdma_pkg::ADCDMA_WR_LO: begin
                // odd byte stands until the file takes it
                if (rf_wr_ready) begin
                    wr_en_next = 1'b0;
                    pair_done = 1'b1;
                    state_next = adcdma_pkg::ADCDMA_IDLE;
                end
            end
            default: begin
                // unused code: park idle with the port quiet
                wr_en_next = 1'b0;
                state_next = adcdma_pkg::ADCDMA_IDLE;
            end
        endcase
    end

    // engine flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= adcdma_pkg::ADCDMA_IDLE;
            chan_reg <= 4'h0;
            res_reg <= 10'h000;
            blk_reg <= 7'h00;
            wr_en_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            wr_data_reg <= 8'h00;
            stored_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            chan_reg <= chan_next;
            res_reg <= res_next;
            blk_reg <= blk_next;
            wr_en_reg <= wr_en_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            stored_reg <= stored_next;
        end
    end

    // ************************************************************
    // sticky per-channel stored flags
    // ************************************************************
    // set only, cleared by reset alone, so software can poll which
    // inputs have had a pair stored at least once
    for (genvar g = 0; g < 16; g++) begin : g_flag
        assign stored_next[g] = stored_reg[g] ||
                                (pair_done && chan_reg == 4'(g));
    end
endmodule

// ### design/adcdma_pkg.sv
// package for the conversion-result address generator
// assumes a 40 MHz core clock and an axi4-lite register port
package adcdma_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] ADCDMA_BASE_IDX = 12'h0_FBD; // printed index
    localparam logic [13:0] ADCDMA_BASE_ADDR = {ADCDMA_BASE_IDX, 2'b00};
    localparam logic [11:0] ADCDMA_STAT_IDX = 12'h0_FBE;
    localparam logic [13:0] ADCDMA_STAT_ADDR = {ADCDMA_STAT_IDX, 2'b00};
    localparam logic [7:0] ADCDMA_BASE_RST = 8'h00;
    localparam int ADCDMA_BASE_LSB = 1;
    localparam int ADCDMA_BASE_MSB = 7;
    // ************************************************************
    // address layout and result split
    // ************************************************************
    localparam int ADCDMA_RF_AW = 12;
    localparam int ADCDMA_CH_W = 4;
    localparam int ADCDMA_RES_W = 10;
    localparam int ADCDMA_HI_LSB = 2;
    localparam logic [1:0] ADCDMA_RESP_OKAY = 2'b00;
    localparam logic [1:0] ADCDMA_RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        ADCDMA_IDLE = 2'b00,
        ADCDMA_WR_HI = 2'b01,
        ADCDMA_WR_LO = 2'b10
    } adcdma_state_t;
endpackage

// ### design/adcdma_addr_gen.sv
// address former for one byte of a result pair
// assumes inputs are stable registered values on the same clock
`timescale 1ns/1ps
module adcdma_addr_gen (
    input wire logic [6:0] base_bits,
    input wire logic [3:0] channel,
    input wire logic odd_byte,
    output logic [11:0] rf_addr
);
    // ************************************************************
    // base in the top, twice the channel in the bottom
    // ************************************************************
    // channel times two plus the byte select gives the low five bits
    always_comb begin
        rf_addr = {base_bits, channel, odd_byte};
    end
endmodule

// ### tb/adcdma_far_model.sv
// converter and register file as seen from the dma engine
// runs on core_clk; the bench asks it for conversions by task
`timescale 1ns/1ps
module adcdma_far_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic conv_ready,
    input wire logic rf_wr_en,
    input wire logic [11:0] rf_wr_addr,
    input wire logic [7:0] rf_wr_data,
    output logic rf_wr_ready,
    output logic conv_done,
    output logic [3:0] conv_channel,
    output logic [9:0] conv_result
);
    logic [7:0] mem [0:4095];
    initial begin
        rf_wr_ready = 1'b1;
        conv_done = 1'b0;
        conv_channel = 4'h0;
        conv_result = 10'h000;
    end
    // byte store; slow mode stalls at random to stretch a pair
    always @(posedge core_clk) begin
        if (rf_wr_en && rf_wr_ready)
            mem[rf_wr_addr] <= rf_wr_data;
        rf_wr_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
    end
    // one done pulse; channel and result scrambled once it ends
    task automatic convert(input logic [3:0] ch, input logic [9:0] res,
                           output logic took);
        @(posedge core_clk);
        conv_done <= 1'b1;
        conv_channel <= ch;
        conv_result <= res;
        @(posedge core_clk);
        took = conv_ready;
        conv_done <= 1'b0;
        conv_channel <= ~ch;
        conv_result <= ~res;
    endtask
endmodule

// ### tb/adcdma_assertions.sv
// port checker for the conversion-result dma engine
// bound into adcdma_top; one clock domain, sync reset
`timescale 1ns/1ps
module adcdma_assertions (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic conv_done,
    input wire logic [3:0] conv_channel,
    input wire logic [9:0] conv_result,
    input wire logic conv_ready,
    input wire logic rf_wr_en,
    input wire logic [11:0] rf_wr_addr,
    input wire logic [7:0] rf_wr_data,
    input wire logic rf_wr_ready,
    input wire logic s_axi_bvalid
);
    logic take;
    logic [3:0] ch_reg, ch_next;
    logic [9:0] res_reg, res_next;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // keep the accepted conversion for the byte compares
    assign take = conv_done && conv_ready;
    always_comb begin
        ch_next = take ? conv_channel : ch_reg;
        res_next = take ? conv_result : res_reg;
    end
    always_ff @(posedge core_clk) begin
        ch_reg <= ch_next;
        res_reg <= res_next;
    end
    a_first_even: assert property (take |-> ##2 rf_wr_en &&
        rf_wr_addr[4:0] == {ch_reg, 1'b0} && rf_wr_data == res_reg[9:2])
        else $error("first byte wrong after conversion");
    a_odd_follows: assert property (rf_wr_en && rf_wr_ready &&
        !rf_wr_addr[0] |=> rf_wr_en && rf_wr_addr == $past(rf_wr_addr) + 1)
        else $error("odd byte not at next address");
    a_odd_data: assert property (rf_wr_en && rf_wr_addr[0] |->
        rf_wr_data == {6'h00, res_reg[1:0]})
        else $error("odd byte data wrong");
    a_upper_held: assert property (rf_wr_en && $past(rf_wr_en) |->
        $stable(rf_wr_addr[11:5]))
        else $error("block address moved within pair");
    a_busy_refuses: assert property (rf_wr_en |-> !conv_ready)
        else $error("done accepted while writing");
    a_write_cause: assert property ($rose(rf_wr_en) |-> $past(take, 2))
        else $error("write without completed conversion");
    a_pair_ends: assert property (rf_wr_en && rf_wr_ready &&
        rf_wr_addr[0] |=> !rf_wr_en && conv_ready)
        else $error("more than two bytes written");
    c_take: cover property (take);
    c_stall: cover property (rf_wr_en && !rf_wr_ready);
    c_bresp: cover property (s_axi_bvalid);
endmodule
bind adcdma_top adcdma_assertions adcdma_assertions_i (.core_clk, .reset,
    .conv_done, .conv_channel, .conv_result, .conv_ready, .rf_wr_en,
    .rf_wr_addr, .rf_wr_data, .rf_wr_ready, .s_axi_bvalid);

// ### tb/tb.sv
// self-checking bench for the conversion-result dma engine
// axi4-lite master tasks here; converter and rf in the far model
`timescale 1ns/1ps
module tb;
    logic core_clk, reset, slow, took;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, conv_done, conv_ready;
    logic rf_wr_en, rf_wr_ready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdata;
    logic [3:0] s_axi_wstrb, conv_channel;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [9:0] conv_result;
    logic [11:0] rf_wr_addr;
    logic [7:0] rf_wr_data, base;
    logic [7:0] exp_mem [0:4095];
    logic [31:0] base_a;
    int n_fail, check_count, bad;
    adcdma_top adcdma_top_i (.core_clk, .reset, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .conv_done,
        .conv_channel, .conv_result, .conv_ready, .rf_wr_en, .rf_wr_addr,
        .rf_wr_data, .rf_wr_ready);
    adcdma_far_model adcdma_far_model_i (.core_clk, .slow, .conv_ready,
        .rf_wr_en, .rf_wr_addr, .rf_wr_data, .rf_wr_ready, .conv_done,
        .conv_channel, .conv_result);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ************************************************************
    // bus master: valids held until taken, ready held until answer
    // ************************************************************
    task automatic axi_wr(input logic [31:0] a, d, input logic [3:0] st);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [31:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdata = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // base write with strobe; bit 0 always reads back as zero
    task automatic set_base(input logic [7:0] v, input logic [3:0] st);
        axi_wr(base_a, {24'h00_0000, v}, st);
        check("base bresp", adcdma_pkg::ADCDMA_RESP_OKAY, resp);
        if (st[0]) base = {v[7:1], 1'b0};
        axi_rd(base_a);
        check("base readback", {24'h00_0000, base}, rdata);
    endtask
    // expected bytes are booked at the take, so a base change
    // made during the pair must not move it
    task automatic run_conv(input logic [3:0] ch, input logic [9:0] res);
        // skip the edge of a take that just happened; conv_ready read
        // right at it still shows the old idle state
        @(posedge core_clk);
        while (!conv_ready) @(posedge core_clk);
        adcdma_far_model_i.convert(ch, res, took);
        check("done taken", 1, took);
        exp_mem[{base[7:1], ch, 1'b0}] = res[9:2];
        exp_mem[{base[7:1], ch, 1'b1}] = {6'h00, res[1:0]};
    endtask
    initial begin
        reset = 1'b1;
        slow = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'h0;
        base = adcdma_pkg::ADCDMA_BASE_RST;
        base_a = {18'h0_0000, adcdma_pkg::ADCDMA_BASE_ADDR};
        bad = $urandom(32'h55ab7e7d);
        bad = 0;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        axi_rd(base_a);
        check("base reset", 32'h0000_0000, rdata);
        axi_rd(32'h0000_0100);
        check("unmapped rresp", adcdma_pkg::ADCDMA_RESP_SLVERR, resp);
        check("unmapped rdata", 32'h0000_0000, rdata);
        axi_wr(32'h0000_0100, 32'h0000_00ff, 4'hf);
        check("unmapped bresp", adcdma_pkg::ADCDMA_RESP_SLVERR, resp);
        axi_rd(base_a);
        check("base kept", 32'h0000_0000, rdata);
        // table case: base 72, every channel
        set_base(8'h72, 4'hf);
        for (int c = 0; c < 16; c++) run_conv(4'(c), 10'($urandom));
        // random bases, strobe-less writes, stalls, busy refusals
        repeat (40) begin
            slow <= 1'($urandom_range(1));
            run_conv(4'($urandom), 10'($urandom));
            // second done while the pair is still being written
            adcdma_far_model_i.convert(4'($urandom), 10'($urandom), took);
            check("busy done ignored", 0, took);
            set_base(8'($urandom), 4'($urandom));
        end
        while (!conv_ready) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        // every channel was stored in the table case; engine idle
        axi_rd({18'h0_0000, adcdma_pkg::ADCDMA_STAT_ADDR});
        check("stored flags", 32'h0000_ffff, rdata);
        for (int a = 0; a < 4096; a++)
            if (adcdma_far_model_i.mem[a] !== exp_mem[a]) bad++;
        check("stored byte mismatches", 0, 32'(bad));
        close_out;
    end
    // hang guard, far above the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        close_out;
    end
endmodule
